// *** src/mul_div_coprocessor.v ***
// Multiply/divide/multiply-accumulate coprocessor with byte-wide register slots.
// Assumes the host CPU issues one register transfer per cycle on the CPU clock.
`timescale 1ns/1ps
`include "muldiv_defs.vh"

module mul_div_coprocessor #(
    parameter [7:0] IDENT_VALUE = 8'h5a // Arbitrary identification value.
) (
    input wire ref_clk_i,
    input wire arst_n_i,
    input wire [3:0] cr_addr_i,
    input wire cr_wr_i,
    input wire [7:0] cr_wdata_i,
    input wire cr_rd_i,
    output reg [7:0] cr_rdata_o,
    output reg busy_o
);

    ////////////////////////////////////////////////////////////////////////
    // Architectural state.
    reg [63:0] opnd;
    reg [7:0] mode;
    reg [7:0] flags;
    reg [4:0] cnt;
    reg [2:0] run_sel;
    reg run_sign;
    reg [63:0] snap;

    // Operand bytes as they will stand after this cycle's host write.
    reg [63:0] next_opnd;
    integer i;

    // Merge a host byte write into the operand image.
    always @* begin
        next_opnd = opnd;
        for (i = 0; i < 8; i = i + 1) begin
            if (cr_wr_i && (cr_addr_i == i[3:0])) begin
                next_opnd[8*i +: 8] = cr_wdata_i;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Start decode.
    wire [2:0] sel = mode[`MD_SEL_HI:`MD_SEL_LO];
    wire sel_valid = (sel == `MD_OP_MUL) || (sel == `MD_OP_DIV16) ||
                     (sel == `MD_OP_MAC) || (sel == `MD_OP_MACSAT) ||
                     (sel == `MD_OP_DIV32);
    wire trigger = cr_wr_i && (cr_addr_i == `MD_IDX_OPND_LAST);
    // The enable bit is sampled only here, so a running job is never cut short.
    wire start = trigger && mode[`MD_EN_BIT] && sel_valid && !busy_o;

    // Latency chosen per operation; reserved codes never reach this point.
    reg [4:0] lat;
    always @* begin
        case (sel)
            `MD_OP_DIV16: lat = `MD_LAT_DIV16;
            `MD_OP_DIV32: lat = `MD_LAT_DIV32;
            default: lat = `MD_LAT_MUL;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Arithmetic units work from a snapshot taken at the trigger, so host
    // writes during a calculation cannot disturb it.
    wire run_mac = (run_sel == `MD_OP_MAC) || (run_sel == `MD_OP_MACSAT);
    wire run_div = (run_sel == `MD_OP_DIV16) || (run_sel == `MD_OP_DIV32);
    wire [31:0] prod;
    wire [31:0] mac_res;
    wire mac_carry;
    wire mac_ovf;
    wire mac_sat;
    wire [31:0] quot;
    wire [31:0] rem;
    wire div_zero;
    wire div_ovf;
    // The 16-bit divisor is widened in the selected sign mode.
    wire [31:0] divisor = (run_sel == `MD_OP_DIV16) ?
                          {{16{run_sign & snap[47]}}, snap[47:32]} : snap[63:32];

    mul_acc_unit u_mac (
        .fac_a_i(snap[47:32]),
        .fac_b_i(snap[63:48]),
        .acc_i(snap[31:0]),
        .signed_i(run_sign),
        .sat_i(run_sel == `MD_OP_MACSAT),
        .prod_o(prod),
        .result_o(mac_res),
        .carry_o(mac_carry),
        .ovf_o(mac_ovf),
        .sat_hit_o(mac_sat)
    );

    div_unit u_div (
        .dividend_i(snap[31:0]),
        .divisor_i(divisor),
        .signed_i(run_sign),
        .quot_o(quot),
        .rem_o(rem),
        .div_zero_o(div_zero),
        .ovf_o(div_ovf)
    );

    // Result word written back to bytes 0 to 3.
    wire [31:0] res_lo = run_div ? quot : (run_mac ? mac_res : prod);
    wire done = busy_o && (cnt == 5'h00);

    ////////////////////////////////////////////////////////////////////////
    // Flag update at completion, applied on top of any host write this cycle.
    reg [7:0] next_flags;
    always @* begin
        next_flags = flags;
        if (cr_wr_i && (cr_addr_i == `MD_IDX_FLAGS)) begin
            // Busy bit is hardware owned; host writes to it are dropped.
            next_flags = {cr_wdata_i[7:1], 1'b0};
        end
        if (done) begin
            next_flags[`MD_ZERO_BIT] = (res_lo == 32'h00000000);
            if (run_div) begin
                next_flags[`MD_CARRY_BIT] = div_zero;
                if (run_sign) begin
                    next_flags[`MD_NEG_BIT] = quot[31];
                    next_flags[`MD_OVF_BIT] = div_ovf;
                end
            end else if (run_mac) begin
                next_flags[`MD_CARRY_BIT] = mac_carry;
                next_flags[`MD_NEG_BIT] = mac_res[31];
                next_flags[`MD_OVF_BIT] = mac_ovf;
                // Set wins over a same-cycle software clear of the sticky bit.
                if (mac_sat) begin
                    next_flags[`MD_SAT_BIT] = 1'b1;
                end
            end else if (run_sign) begin
                next_flags[`MD_NEG_BIT] = prod[31];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Operation sequencer: busy, countdown and snapshot.
    always @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            busy_o <= 1'b0;
            cnt <= 5'h00;
            run_sel <= `MD_OP_MUL;
            run_sign <= 1'b0;
            snap <= `MD_OPND_RST;
        end else if (start) begin
            busy_o <= 1'b1;
            cnt <= lat - 5'h01;
            run_sel <= sel;
            run_sign <= mode[`MD_SIGN_BIT];
            snap <= next_opnd;
        end else if (done) begin
            busy_o <= 1'b0;
        end else if (busy_o) begin
            cnt <= cnt - 5'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Operand bytes: host writes, overridden by results at completion.
    always @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            opnd <= `MD_OPND_RST;
        end else if (done) begin
            opnd[31:0] <= res_lo;
            if (run_sel == `MD_OP_DIV16) begin
                opnd[47:32] <= rem[15:0];
                opnd[63:48] <= next_opnd[63:48];
            end else if (run_sel == `MD_OP_DIV32) begin
                opnd[63:32] <= rem;
            end else begin
                opnd[63:32] <= next_opnd[63:32];
            end
        end else begin
            opnd <= next_opnd;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode control and result flag registers.
    always @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mode <= `MD_MODE_RST;
            flags <= `MD_FLAGS_RST;
        end else begin
            if (cr_wr_i && (cr_addr_i == `MD_IDX_MODE)) begin
                mode <= cr_wdata_i;
            end
            flags <= next_flags;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data is registered; empty slots return zero.
    reg [7:0] rd_val;
    always @* begin
        case (cr_addr_i)
            `MD_IDX_MODE: rd_val = mode;
            `MD_IDX_FLAGS: rd_val = {flags[7:1], busy_o};
            `MD_IDX_IDENT: rd_val = IDENT_VALUE;
            4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7: rd_val = opnd[8*cr_addr_i +: 8];
            default: rd_val = 8'h00;
        endcase
    end

    // The read port holds its last value between reads.
    always @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cr_rdata_o <= 8'h00;
        end else if (cr_rd_i) begin
            cr_rdata_o <= rd_val;
        end
    end

endmodule // mul_div_coprocessor

// *** src/muldiv_defs.vh ***
// Constants shared by the multiply/divide coprocessor and its arithmetic units.
// Assumes it is included by bare name from files under src/.
`ifndef MULDIV_DEFS_VH
`define MULDIV_DEFS_VH

// Coprocessor register slot indices.
`define MD_IDX_OPND_LAST 4'h7
`define MD_IDX_MODE 4'h8
`define MD_IDX_FLAGS 4'h9
`define MD_IDX_IDENT 4'hf

// Operation select codes.
`define MD_OP_MUL 3'h0
`define MD_OP_DIV16 3'h1
`define MD_OP_MAC 3'h2
`define MD_OP_MACSAT 3'h3
`define MD_OP_DIV32 3'h5

// Mode control field positions.
`define MD_SEL_HI 2
`define MD_SEL_LO 0
`define MD_SIGN_BIT 4
`define MD_EN_BIT 7

// Result flag positions.
`define MD_BUSY_BIT 0
`define MD_SAT_BIT 3
`define MD_OVF_BIT 4
`define MD_NEG_BIT 5
`define MD_ZERO_BIT 6
`define MD_CARRY_BIT 7

// Reset values.
`define MD_MODE_RST 8'h00
`define MD_FLAGS_RST 8'h00
`define MD_OPND_RST 64'h0000000000000000

// Latencies in clock cycles.
`define MD_LAT_MUL 5'h04
`define MD_LAT_DIV16 5'h08
`define MD_LAT_DIV32 5'h10

// Saturation bounds.
`define MD_SAT_POS 32'h7fffffff
`define MD_SAT_NEG 32'h80000000
`define MD_SAT_UNS 32'hffffffff

`endif

// *** src/mul_acc_unit.v ***
// Combinational 16x16 multiplier with 32-bit accumulate and saturation.
// Assumes operands are held stable by the caller for the whole operation.
`timescale 1ns/1ps
`include "muldiv_defs.vh"

module mul_acc_unit (
    input wire [15:0] fac_a_i,
    input wire [15:0] fac_b_i,
    input wire [31:0] acc_i,
    input wire signed_i,
    input wire sat_i,
    output wire [31:0] prod_o,
    output wire [31:0] result_o,
    output wire carry_o,
    output wire ovf_o,
    output wire sat_hit_o
);

    ////////////////////////////////////////////////////////////////////////
    // Extend to 34 bits so both signed and unsigned sums keep their range.
    wire [33:0] fa = {{18{signed_i & fac_a_i[15]}}, fac_a_i};
    wire [33:0] fb = {{18{signed_i & fac_b_i[15]}}, fac_b_i};
    wire [33:0] prod34 = fa * fb;
    wire [33:0] acc34 = {{2{signed_i & acc_i[31]}}, acc_i};
    wire [33:0] sum34 = prod34 + acc34;
    wire [32:0] raw_sum = {1'b0, acc_i} + {1'b0, prod34[31:0]};
    wire sgn_ovf = (sum34[33:31] != 3'b000) && (sum34[33:31] != 3'b111);
    wire uns_ovf = (sum34[33:32] != 2'b00);
    wire [31:0] clamp = signed_i ? (sum34[33] ? `MD_SAT_NEG : `MD_SAT_POS) : `MD_SAT_UNS;

    ////////////////////////////////////////////////////////////////////////
    // Carry is the raw carry out of the 32-bit add in both sign modes.
    assign prod_o = prod34[31:0];
    assign carry_o = raw_sum[32];
    assign ovf_o = signed_i ? sgn_ovf : uns_ovf;
    assign sat_hit_o = sat_i & ovf_o;
    assign result_o = sat_hit_o ? clamp : sum34[31:0];

endmodule // mul_acc_unit

// *** src/div_unit.v ***
// Combinational 32-bit divider working on magnitudes, signed or unsigned.
// Assumes the caller widens a 16-bit divisor in the selected sign mode before presenting it.
`timescale 1ns/1ps
`include "muldiv_defs.vh"

module div_unit (
    input wire [31:0] dividend_i,
    input wire [31:0] divisor_i,
    input wire signed_i,
    output wire [31:0] quot_o,
    output wire [31:0] rem_o,
    output wire div_zero_o,
    output wire ovf_o
);

    ////////////////////////////////////////////////////////////////////////
    // Magnitudes; the most negative value stays correct as unsigned 2^31.
    wire neg_n = signed_i & dividend_i[31];
    wire neg_d = signed_i & divisor_i[31];
    wire [31:0] mag_n = neg_n ? (32'h00000000 - dividend_i) : dividend_i;
    wire [31:0] mag_d = neg_d ? (32'h00000000 - divisor_i) : divisor_i;
    wire [31:0] safe_d = (mag_d == 32'h00000000) ? 32'h00000001 : mag_d;
    wire [31:0] q_mag = mag_n / safe_d;
    wire [31:0] r_mag = mag_n % safe_d;

    ////////////////////////////////////////////////////////////////////////
    // A zero divisor yields all ones and leaves the dividend as remainder.
    assign div_zero_o = (divisor_i == 32'h00000000);
    assign quot_o = div_zero_o ? 32'hffffffff :
                    ((neg_n ^ neg_d) ? (32'h00000000 - q_mag) : q_mag);
    assign rem_o = div_zero_o ? dividend_i : (neg_n ? (32'h00000000 - r_mag) : r_mag);
    assign ovf_o = signed_i && (dividend_i == `MD_SAT_NEG) && (divisor_i == 32'hffffffff);

endmodule // div_unit

// *** test/mul_div_coprocessor_properties.sv ***
// Checker for the coprocessor register port and calculation timing.
// Assumes it is bound to the coprocessor top and sees only its ports.
`timescale 1ns/1ps
module mul_div_coprocessor_properties #(
    parameter [7:0] IDENT_VALUE = 8'h5a
) (
    input wire ref_clk_i,
    input wire arst_n_i,
    input wire [3:0] cr_addr_i,
    input wire cr_wr_i,
    input wire [7:0] cr_wdata_i,
    input wire cr_rd_i,
    input wire [7:0] cr_rdata_o,
    input wire busy_o
);
    reg [7:0] mode_q;
    reg [2:0] op_q;
    reg [4:0] run_len;
    wire trig = cr_wr_i && (cr_addr_i == 4'h7);
    wire sel_ok = (mode_q[2:0] <= 3'h3) || (mode_q[2:0] == 3'h5);
    wire [4:0] lat = (op_q == 3'h1) ? 5'h08 : ((op_q == 3'h5) ? 5'h10 : 5'h04);
    // Shadow of the mode slot, the op taken at a trigger, and the busy run length.
    always @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mode_q <= 8'h00;
            op_q <= 3'h0;
            run_len <= 5'h00;
        end else begin
            if (cr_wr_i && cr_addr_i == 4'h8) begin
                mode_q <= cr_wdata_i;
            end
            if (trig && !busy_o) begin
                op_q <= mode_q[2:0];
            end
            run_len <= busy_o ? run_len + 5'h01 : 5'h00;
        end
    end
    ////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!arst_n_i);
    chk_start_needs_en: assert property ($rose(busy_o) |->
        $past(trig) && $past(mode_q[7]))
        else $error("busy rose without an enabled trigger");
    chk_trigger_starts: assert property ((trig && !busy_o && mode_q[7] && sel_ok)
        |=> busy_o)
        else $error("valid trigger did not start");
    chk_reserved_idle: assert property ((trig && !busy_o && !sel_ok) |=> !busy_o)
        else $error("reserved code started work");
    chk_op_latency: assert property ($fell(busy_o) |-> run_len == lat)
        else $error("calculation length wrong");
    chk_flag_busy_bit: assert property ((cr_rd_i && cr_addr_i == 4'h9)
        |=> cr_rdata_o[0] == $past(busy_o))
        else $error("busy flag bit disagrees with busy");
    chk_ident_read: assert property ((cr_rd_i && cr_addr_i == 4'hf)
        |=> cr_rdata_o == IDENT_VALUE)
        else $error("ident slot value wrong");
    chk_unused_zero: assert property (cr_rd_i &&
        (cr_addr_i >= 4'ha) && (cr_addr_i <= 4'he) |=> cr_rdata_o == 8'h00)
        else $error("unused slot not zero");
    chk_mode_readback: assert property ((cr_rd_i && cr_addr_i == 4'h8)
        |=> cr_rdata_o == $past(mode_q))
        else $error("mode slot readback wrong");
endmodule // mul_div_coprocessor_properties
bind mul_div_coprocessor mul_div_coprocessor_properties #(.IDENT_VALUE(IDENT_VALUE)) i_props (
    .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .cr_addr_i(cr_addr_i), .cr_wr_i(cr_wr_i),
    .cr_wdata_i(cr_wdata_i), .cr_rd_i(cr_rd_i), .cr_rdata_o(cr_rdata_o), .busy_o(busy_o));

// *** test/host_cpu_model.sv ***
// Host CPU model issuing one-byte coprocessor register transfers.
// Assumes the bench calls its tasks after reset is released.
`timescale 1ns/1ps
module host_cpu_model (
    input wire ref_clk_i,
    input wire [7:0] cr_rdata_i,
    output reg [3:0] cr_addr_o,
    output reg cr_wr_o,
    output reg [7:0] cr_wdata_o,
    output reg cr_rd_o
);
    initial begin
        cr_addr_o = 4'h0;
        cr_wr_o = 1'b0;
        cr_wdata_o = 8'h00;
        cr_rd_o = 1'b0;
    end
    ////////////////////////////////////////////////////////////
    // Each strobe stands for exactly one edge; stale data is inverted on release.
    task wr(input [3:0] a, input [7:0] d);
    begin
        @(posedge ref_clk_i);
        cr_addr_o <= a;
        cr_wdata_o <= d;
        cr_wr_o <= 1'b1;
        @(posedge ref_clk_i);
        cr_wr_o <= 1'b0;
        cr_wdata_o <= ~d;
    end
    endtask
    task rd(input [3:0] a, output [7:0] d);
    begin
        @(posedge ref_clk_i);
        cr_addr_o <= a;
        cr_rd_o <= 1'b1;
        @(posedge ref_clk_i);
        cr_rd_o <= 1'b0;
        #1;
        d = cr_rdata_i;
    end
    endtask
    // Idle cycles after a trigger before the result is fetched.
    task settle(input integer n);
    begin
        repeat (n) @(posedge ref_clk_i);
    end
    endtask
endmodule // host_cpu_model

// *** test/mul_div_coprocessor_tb_top.sv ***
// Self-checking bench for the coprocessor, driven through the host model.
// Assumes the checker is bound to the design by its own file.
`timescale 1ns/1ps
module mul_div_coprocessor_tb_top;
    localparam [7:0] IDENT = 8'h3c; // Arbitrary identification value.
    reg ref_clk_i = 1'b0;
    reg arst_n_i = 1'b0;
    wire [3:0] cr_addr;
    wire cr_wr;
    wire cr_rd;
    wire [7:0] cr_wdata;
    wire [7:0] cr_rdata;
    wire busy;
    integer error_cnt = 0;
    integer total_checks = 0;
    integer i;
    integer k;
    reg [7:0] b;
    reg [31:0] v;
    reg [31:0] e;
    always #12.5 ref_clk_i = ~ref_clk_i;
    host_cpu_model i_host (.ref_clk_i(ref_clk_i), .cr_rdata_i(cr_rdata), .cr_addr_o(cr_addr),
        .cr_wr_o(cr_wr), .cr_wdata_o(cr_wdata), .cr_rd_o(cr_rd));
    mul_div_coprocessor #(.IDENT_VALUE(IDENT)) i_dut (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
        .cr_addr_i(cr_addr), .cr_wr_i(cr_wr), .cr_wdata_i(cr_wdata), .cr_rd_i(cr_rd),
        .cr_rdata_o(cr_rdata), .busy_o(busy));
    ////////////////////////////////////////////////////////////
    task chk(input string name, input [31:0] exp, input [31:0] got);
    begin
        total_checks = total_checks + 1;
        if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    end
    endtask
    task rchk(input [3:0] a, input [7:0] exp);
    begin
        i_host.rd(a, b);
        chk("slot", {24'h0, exp}, {24'h0, b});
    end
    endtask
    // Bytes 0..3 read least significant first.
    task rd32(output [31:0] r);
    begin
        for (i = 0; i < 4; i = i + 1) begin
            i_host.rd(i[3:0], b);
            r[8*i +: 8] = b;
        end
    end
    endtask
    // Operands go in first, mode next, the trigger byte last.
    task op(input [7:0] mode, input [63:0] opnd, input integer lat, input exp_busy);
    begin
        for (i = 0; i < 7; i = i + 1) begin
            i_host.wr(i[3:0], opnd[8*i +: 8]);
        end
        i_host.wr(4'h8, mode);
        i_host.wr(4'h7, opnd[63:56]);
        #1;
        chk("busy", {31'h0, exp_busy}, {31'h0, busy});
        i_host.settle(lat);
    end
    endtask
    task summarize;
    begin
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    end
    endtask
    // Watchdog sized well beyond the few hundred cycles the sequence needs.
    initial begin
        #(3000 * 25);
        error_cnt = error_cnt + 1;
        summarize;
    end
    initial begin
        repeat (2) @(posedge ref_clk_i);
        arst_n_i <= 1'b1;
        rchk(4'h8, 8'h00);
        i_host.wr(4'hf, 8'hff);
        i_host.wr(4'hc, 8'hff);
        rchk(4'hf, IDENT);
        rchk(4'hc, 8'h00);
        i_host.wr(4'h9, 8'ha1);
        rchk(4'h9, 8'ha0);
        op(8'h10, {16'haa55, 16'h1234, 32'h0}, 4, 1'b0);
        rd32(v);
        chk("product", 32'h0, v);
        op(8'h80, {16'h1234, 16'h0000, 32'h0}, 4, 1'b1);
        rchk(4'h9, 8'he0);
        op(8'h90, {16'haa55, 16'h1234, 32'h0}, 4, 1'b1);
        e = $signed(16'haa55) * $signed(16'h1234);
        rd32(v);
        chk("product", e, v);
        rchk(4'h9, 8'ha0);
        i_host.wr(4'h9, 8'h00);
        op(8'h81, {32'h0, 32'h12345678}, 8, 1'b1);
        rchk(4'h9, 8'h80);
        op(8'h95, {32'hffffffff, 32'h80000000}, 16, 1'b1);
        rchk(4'h9, 8'h30);
        op(8'h93, {16'h7fff, 16'h7fff, 32'h7fffffff}, 4, 1'b1);
        rd32(v);
        chk("clamp", 32'h7fffffff, v);
        rchk(4'h9, 8'h18);
        op(8'h82, {16'h0001, 16'h0001, 32'hffffffff}, 4, 1'b1);
        rchk(4'h9, 8'hd8);
        op(8'h92, {16'h0001, 16'hffff, 32'h0}, 4, 1'b1);
        rchk(4'h9, 8'h28);
        i_host.wr(4'h9, 8'h00);
        rchk(4'h9, 8'h00);
        op(8'h80, {16'h0002, 16'h0003, 32'h0}, 0, 1'b1);
        i_host.wr(4'h8, 8'h00);
        i_host.settle(4);
        rd32(v);
        chk("product", 32'h6, v);
        i_host.wr(4'h7, 8'h00);
        #1;
        chk("busy", 32'h0, {31'h0, busy});
        // Signed 32/16 division: the 16-bit divisor must be widened with its sign.
        op(8'h91, {16'h0000, 16'hfffe, 32'h00000064}, 8, 1'b1);
        rd32(v);
        chk("quotient", 32'hffffffce, v);
        rchk(4'h4, 8'h00);
        rchk(4'h9, 8'h20);
        // Unsigned 32/32 division must leave the negative and overflow flags alone.
        op(8'h85, {32'h00000007, 32'h00000064}, 16, 1'b1);
        rd32(v);
        chk("quotient", 32'h0000000e, v);
        rchk(4'h4, 8'h02);
        rchk(4'h9, 8'h20);
        i_host.wr(4'h9, 8'h40);
        for (k = 4; k < 8; k = k + 1) begin
            if (k != 5) begin
                op({5'h10, k[2:0]}, {16'h0002, 16'h0003, 32'h9}, 0, 1'b0);
            end
        end
        rchk(4'h9, 8'h40);
        // A reset in mid-calculation must drop the run and clear the mode, flag and operand slots.
        op(8'h95, {32'h00000001, 32'h00000005}, 0, 1'b1);
        @(posedge ref_clk_i);
        arst_n_i <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        arst_n_i <= 1'b1;
        #1;
        chk("busy", 32'h0, {31'h0, busy});
        rchk(4'h8, 8'h00);
        rchk(4'h9, 8'h00);
        rchk(4'h0, 8'h00);
        summarize;
    end
endmodule // mul_div_coprocessor_tb_top
